// [logic/dds_host_port_mode_select.sv]
// Host port of the synthesizer: parallel, serial and direct modulation modes
`timescale 1ns/1ps

module dds_host_port_mode_select
    import dds_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Host pins
    input wire logic [3:0] function_select,
    input wire logic [31:0] port_in,
    input wire logic io_update,
    input wire logic [2:0] profile_select_pins,
    output logic [31:0] port_out,
    output logic [31:0] port_oe,
    // Synthesis core
    output dds_port_pkg::core_word_t core_word
);
    import dds_port_pkg::*;

    // Pin synchronisers; stage 1 feeds only stage 2
    logic [31:0] port_s1_ff, port_s2_ff, port_s3_ff;
    logic [3:0] fsel_s1_ff, fsel_s2_ff;
    logic [2:0] prof_s1_ff, prof_s2_ff, prof_s3_ff;
    logic upd_s1_ff, upd_s2_ff, upd_s3_ff;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            // Idle level, so no read strobe or false edge is seen right after reset
            port_s1_ff <= PORT_IDLE;
            port_s2_ff <= PORT_IDLE;
            port_s3_ff <= PORT_IDLE;
            fsel_s1_ff <= 4'h0;
            fsel_s2_ff <= 4'h0;
            prof_s1_ff <= 3'h0;
            prof_s2_ff <= 3'h0;
            prof_s3_ff <= 3'h0;
            upd_s1_ff <= 1'b0;
            upd_s2_ff <= 1'b0;
            upd_s3_ff <= 1'b0;
        end
        else
        begin
            port_s1_ff <= port_in;
            port_s2_ff <= port_s1_ff;
            port_s3_ff <= port_s2_ff;
            fsel_s1_ff <= function_select;
            fsel_s2_ff <= fsel_s1_ff;
            prof_s1_ff <= profile_select_pins;
            prof_s2_ff <= prof_s1_ff;
            prof_s3_ff <= prof_s2_ff;
            upd_s1_ff <= io_update;
            upd_s2_ff <= upd_s1_ff;
            upd_s3_ff <= upd_s2_ff;
        end
    end

    // Profile registers come in pairs; the pins choose which pair a serial read returns
    function automatic logic [5:0] read_index(input logic [5:0] addr, input logic [2:0] prof);
        logic [5:0] off;
        off = addr - PROFILE_FIRST;
        if (addr >= PROFILE_FIRST && addr <= PROFILE_LAST)
            read_index = PROFILE_FIRST + {2'h0, prof, off[0]};
        else
            read_index = addr;
    endfunction

    // Constant routing table for the direct modes
    function automatic direct_word_t route_direct(input logic [3:0] code, input logic [31:0] p);
        direct_word_t w;
        w = '0;
        case (code)
            4'h2:
            begin
                w.frequency_tuning_word = p;
                w.ftw_mask = 32'hffff_ffff;
            end
            4'h3:
            begin
                w.frequency_tuning_word = {p[15:8], p[7:0], p[31:24], p[23:16]};
                w.ftw_mask = 32'hffff_ffff;
            end
            4'h4:
            begin
                w.phase_offset_word = p[31:16];
                w.amplitude_word = p[15:0];
                w.pow_mask = 16'hffff;
                w.amp_mask = 16'hffff;
            end
            4'h5:
            begin
                w.amplitude_word = p[31:16];
                w.phase_offset_word = p[15:0];
                w.pow_mask = 16'hffff;
                w.amp_mask = 16'hffff;
            end
            4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd:
            begin
                if (code <= 4'h9)
                begin
                    w.frequency_tuning_word = {p[31:8], 8'h00};
                    w.ftw_mask = 32'hffff_ff00;
                end
                else
                begin
                    w.frequency_tuning_word = {8'h00, p[31:8]};
                    w.ftw_mask = 32'h00ff_ffff;
                end
                if (code[0])
                begin
                    w.phase_offset_word = code[1] ? {p[7:0], 8'h00} : {8'h00, p[7:0]};
                    w.pow_mask = code[1] ? 16'hff00 : 16'h00ff;
                end
                else
                begin
                    w.amplitude_word = code[1] ? {p[7:0], 8'h00} : {8'h00, p[7:0]};
                    w.amp_mask = code[1] ? 16'hff00 : 16'h00ff;
                end
            end
            default: w = '0;
        endcase
        route_direct = w;
    endfunction

    // Register storage: buffer written by the host, active used by the core
    logic [3:0][7:0] buf_ff [0:REG_COUNT-1];
    logic [3:0][7:0] active_ff [0:REG_COUNT-1];

    logic mode_par, mode_ser, mode_dir;
    logic transfer_ev;
    logic lsb_first, sdio_input_only, shaping_en, stream_en, matched_en;

    assign mode_par = (fsel_s2_ff == FSEL_PARALLEL);
    assign mode_ser = (fsel_s2_ff == FSEL_SERIAL);
    assign mode_dir = (fsel_s2_ff >= FSEL_DIRECT_FIRST) && (fsel_s2_ff <= FSEL_DIRECT_LAST);
    assign transfer_ev = (upd_s2_ff && !upd_s3_ff) || (prof_s2_ff != prof_s3_ff);
    assign lsb_first = active_ff[FIRST_CTRL_ADDR][0][CTRL1_LSB_FIRST_BIT];
    assign sdio_input_only = active_ff[FIRST_CTRL_ADDR][0][CTRL1_SDIO_INPUT_ONLY_BIT];
    assign shaping_en = active_ff[FIRST_CTRL_ADDR][1][CTRL1_OUTPUT_SHAPING_BIT-8];
    assign stream_en = active_ff[FIRST_CTRL_ADDR][2][CTRL1_STREAM_BIT-16];
    assign matched_en = active_ff[SECOND_CTRL_ADDR][1][CTRL2_MATCHED_LATENCY_BIT-8];

    // Parallel mode decode
    logic [7:0] par_addr, par_addr_lo;
    logic par_wide, par_rd, par_wr_ev;

    assign par_addr = port_s2_ff[15:8];
    assign par_addr_lo = par_addr - 8'h01;
    assign par_wide = port_s2_ff[PAR_WIDE_BIT];
    assign par_rd = mode_par && !port_s2_ff[PAR_RD_N_BIT];
    assign par_wr_ev = mode_par && !port_s2_ff[PAR_WR_N_BIT] && port_s3_ff[PAR_WR_N_BIT];

    // Serial pins (only bits 4:0 are looked at)
    logic cs_n, sync_io, sclk_rise, sclk_fall, sdio_bit;

    assign cs_n = port_s2_ff[SER_CS_N_BIT];
    assign sync_io = port_s2_ff[SER_SYNC_BIT];
    assign sclk_rise = port_s2_ff[SER_SCLK_BIT] && !port_s3_ff[SER_SCLK_BIT];
    assign sclk_fall = !port_s2_ff[SER_SCLK_BIT] && port_s3_ff[SER_SCLK_BIT];
    assign sdio_bit = port_s2_ff[SER_SDIO_BIT];

    serial_state_t ser_state_ff;
    logic [2:0] bit_cnt_ff;
    logic [1:0] byte_cnt_ff;
    logic [7:0] shift_ff;
    logic ser_read_ff;
    logic [5:0] ser_addr_ff;
    logic [31:0] rd_word_ff;
    logic ser_bit_out_ff;
    logic [7:0] nxt_shift;
    logic ser_edge, ser_byte_done, ser_wr_ev;
    logic [1:0] byte_idx;
    logic [4:0] rd_bit_idx;

    // Edges count only while selected and not held in resync
    assign ser_edge = mode_ser && !sync_io && !cs_n && sclk_rise;
    assign nxt_shift = lsb_first ? {sdio_bit, shift_ff[7:1]} : {shift_ff[6:0], sdio_bit};
    assign ser_byte_done = ser_edge && (bit_cnt_ff == BIT_LAST);
    assign ser_wr_ev = ser_byte_done && (ser_state_ff == SER_DATA) && !ser_read_ff;
    // MSB-first sends the top byte first, LSB-first the bottom byte
    assign byte_idx = lsb_first ? (BYTE_LAST - byte_cnt_ff) : byte_cnt_ff;
    assign rd_bit_idx = {byte_idx, lsb_first ? bit_cnt_ff : (BIT_LAST - bit_cnt_ff)};

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ser_state_ff <= SER_INSTR;
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 2'h0;
            shift_ff <= 8'h00;
            ser_read_ff <= 1'b0;
            ser_addr_ff <= 6'h00;
            rd_word_ff <= 32'h0000_0000;
        end
        else if (!mode_ser || sync_io)
        begin
            ser_state_ff <= SER_INSTR;
            bit_cnt_ff <= 3'h0;
        end
        else if (ser_edge)
        begin
            shift_ff <= nxt_shift;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == BIT_LAST)
            begin
                case (ser_state_ff)
                    SER_INSTR:
                    begin
                        ser_read_ff <= nxt_shift[INSTR_READ_BIT];
                        ser_addr_ff <= nxt_shift[5:0];
                        byte_cnt_ff <= BYTE_LAST;
                        rd_word_ff <= active_ff[read_index(nxt_shift[5:0], prof_s2_ff)];
                        ser_state_ff <= SER_DATA;
                    end
                    default:
                    begin
                        if (byte_cnt_ff == 2'h0)
                            ser_state_ff <= SER_INSTR;
                        else
                            byte_cnt_ff <= byte_cnt_ff - 2'h1;
                    end
                endcase
            end
        end
    end

    // Read data changes on the falling serial edge so the host samples on the rising one
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            ser_bit_out_ff <= 1'b0;
        else if (mode_ser && !cs_n && sclk_fall && ser_state_ff == SER_DATA && ser_read_ff)
            ser_bit_out_ff <= rd_word_ff[rd_bit_idx];
    end

    // Port buffer, written from the parallel and serial paths
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < REG_COUNT; i++)
                buf_ff[i] <= '0;
        end
        else if (par_wr_ev)
        begin
            if (par_wide)
            begin
                buf_ff[par_addr[7:2]][par_addr[1:0]] <= port_s2_ff[31:24];
                buf_ff[par_addr_lo[7:2]][par_addr_lo[1:0]] <= port_s2_ff[23:16];
            end
            else
                buf_ff[par_addr[7:2]][par_addr[1:0]] <= port_s2_ff[23:16];
        end
        else if (ser_wr_ev)
            buf_ff[ser_addr_ff][byte_idx] <= nxt_shift;
    end

    // Active registers only change on a transfer
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < REG_COUNT; i++)
                active_ff[i] <= '0;
        end
        else if (transfer_ev)
            active_ff <= buf_ff;
    end

    // Port drive: parallel read data or serial read bit
    logic [7:0] rd_hi_byte, rd_lo_byte;

    assign rd_hi_byte = active_ff[par_addr[7:2]][par_addr[1:0]];
    assign rd_lo_byte = active_ff[par_addr_lo[7:2]][par_addr_lo[1:0]];

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            port_out <= 32'h0000_0000;
            port_oe <= 32'h0000_0000;
        end
        else
        begin
            port_out <= 32'h0000_0000;
            port_oe <= 32'h0000_0000;
            if (par_rd)
            begin
                if (par_wide)
                begin
                    port_out[31:16] <= {rd_hi_byte, rd_lo_byte};
                    port_oe[31:16] <= 16'hffff;
                end
                else
                begin
                    port_out[23:16] <= rd_hi_byte;
                    port_oe[23:16] <= 8'hff;
                end
            end
            else if (mode_ser && !cs_n && ser_state_ff == SER_DATA && ser_read_ff)
            begin
                if (sdio_input_only)
                begin
                    port_out[SER_SDO_BIT] <= ser_bit_out_ff;
                    port_oe[SER_SDO_BIT] <= 1'b1;
                end
                else
                begin
                    port_out[SER_SDIO_BIT] <= ser_bit_out_ff;
                    port_oe[SER_SDIO_BIT] <= 1'b1;
                end
            end
        end
    end

    // Direct modulation path
    logic [3:0] sample_cnt_ff;
    logic [31:0] stg_ftw_ff;
    logic [15:0] stg_pow_ff, stg_amp_ff;
    core_word_t src_ff, pipe1_ff, pipe2_ff;
    direct_word_t route;
    logic [31:0] nxt_ftw;
    logic [15:0] nxt_pow, nxt_amp;
    logic sample_ev;

    assign sample_ev = mode_dir && (sample_cnt_ff == DIRECT_SAMPLE_LAST);
    assign route = route_direct(fsel_s2_ff, port_s2_ff);
    assign nxt_ftw = (stg_ftw_ff & ~route.ftw_mask) | (route.frequency_tuning_word & route.ftw_mask);
    assign nxt_pow = (stg_pow_ff & ~route.pow_mask) | (route.phase_offset_word & route.pow_mask);
    assign nxt_amp = (stg_amp_ff & ~route.amp_mask) | (route.amplitude_word & route.amp_mask);

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            sample_cnt_ff <= 4'h0;
        else
            sample_cnt_ff <= sample_cnt_ff + 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            stg_ftw_ff <= 32'h0000_0000;
            stg_pow_ff <= 16'h0000;
            stg_amp_ff <= 16'h0000;
        end
        else if (sample_ev)
        begin
            stg_ftw_ff <= nxt_ftw;
            stg_pow_ff <= nxt_pow;
            stg_amp_ff <= nxt_amp;
        end
    end

    // Core source: streamed on each sample, else loaded by a transfer
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            src_ff <= '0;
        else if (sample_ev && stream_en)
        begin
            src_ff.freq <= nxt_ftw;
            src_ff.phase <= nxt_pow;
            if (shaping_en)
                src_ff.amplitude_word <= nxt_amp[AMP_BITS-1:0];
        end
        else if (transfer_ev)
        begin
            src_ff.freq <= stg_ftw_ff;
            src_ff.phase <= stg_pow_ff;
            if (shaping_en)
                src_ff.amplitude_word <= stg_amp_ff[AMP_BITS-1:0];
        end
    end

    // Unmatched paths: frequency 1, phase 2, amplitude 3 cycles; matched: all 3
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pipe1_ff <= '0;
            pipe2_ff <= '0;
            core_word <= '0;
        end
        else
        begin
            pipe1_ff <= src_ff;
            pipe2_ff <= pipe1_ff;
            if (matched_en)
                core_word <= pipe2_ff;
            else
            begin
                core_word.freq <= src_ff.freq;
                core_word.phase <= pipe1_ff.phase;
                core_word.amplitude_word <= pipe2_ff.amplitude_word;
            end
        end
    end

endmodule

// [logic/dds_port_pkg.sv]
// Constants and types shared by the synthesizer host port
package dds_port_pkg;

    // Function-select codes
    localparam logic [3:0] FSEL_PARALLEL = 4'h0;
    localparam logic [3:0] FSEL_SERIAL = 4'h1;
    localparam logic [3:0] FSEL_DIRECT_FIRST = 4'h2;
    localparam logic [3:0] FSEL_DIRECT_LAST = 4'hd;

    // Parallel mode control bit positions on the port
    localparam int PAR_WIDE_BIT = 0;
    localparam int PAR_RD_N_BIT = 1;
    localparam int PAR_WR_N_BIT = 2;
    // Port level at rest: read and write strobes and chip select high
    localparam logic [31:0] PORT_IDLE = 32'h0000_0007;

    // Serial mode pin positions on the port
    localparam int SER_CS_N_BIT = 0;
    localparam int SER_SCLK_BIT = 1;
    localparam int SER_SDIO_BIT = 2;
    localparam int SER_SDO_BIT = 3;
    localparam int SER_SYNC_BIT = 4;

    // Control register addresses and bit positions
    localparam logic [5:0] FIRST_CTRL_ADDR = 6'h00;
    localparam logic [5:0] SECOND_CTRL_ADDR = 6'h01;
    localparam int CTRL1_LSB_FIRST_BIT = 0;
    localparam int CTRL1_SDIO_INPUT_ONLY_BIT = 1;
    localparam int CTRL1_OUTPUT_SHAPING_BIT = 8;
    localparam int CTRL1_STREAM_BIT = 17;
    localparam int CTRL2_MATCHED_LATENCY_BIT = 15;

    // Profile register window
    localparam logic [5:0] PROFILE_FIRST = 6'h0b;
    localparam logic [5:0] PROFILE_LAST = 6'h1a;

    // Serial framing
    localparam int INSTR_READ_BIT = 7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] BYTE_LAST = 2'h3;
    localparam int REG_COUNT = 64;

    // Direct mode timing and amplitude resolution
    localparam logic [3:0] DIRECT_SAMPLE_LAST = 4'hf;
    localparam int AMP_BITS = 12;

    typedef enum logic {SER_INSTR, SER_DATA} serial_state_t;

    typedef struct packed {
        logic [31:0] freq;
        logic [15:0] phase;
        logic [AMP_BITS-1:0] amplitude_word;
    } core_word_t;

    typedef struct packed {
        logic [31:0] frequency_tuning_word;
        logic [15:0] phase_offset_word;
        logic [15:0] amplitude_word;
        logic [31:0] ftw_mask;
        logic [15:0] pow_mask;
        logic [15:0] amp_mask;
    } direct_word_t;

endpackage

// [verification/dds_host_port_mode_select_test.sv]
// Self-checking bench for the synthesizer host port
`timescale 1ns/1ps
module dds_host_port_mode_select_test;
    import dds_port_pkg::*;
    logic clk;
    logic reset_n;
    logic [3:0] function_select;
    logic [31:0] par_in;
    logic [31:0] port_in;
    logic io_update;
    logic [2:0] profile_select_pins;
    logic [31:0] port_out;
    logic [31:0] port_oe;
    core_word_t core_word;
    logic [4:0] ser_pins;
    logic [31:0] rd;
    int n_mismatch;
    int checks;

    assign port_in = (function_select == FSEL_SERIAL) ? {par_in[31:5], ser_pins} : par_in;

    dds_host_port_mode_select i_dds_host_port_mode_select (.clk(clk), .reset_n(reset_n),
        .function_select(function_select), .port_in(port_in), .io_update(io_update),
        .profile_select_pins(profile_select_pins), .port_out(port_out), .port_oe(port_oe),
        .core_word(core_word));
    host_serial_model i_host_serial_model (.clk(clk), .port_out(port_out),
        .port_oe(port_oe), .ser_pins(ser_pins));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task cmp(input logic [63:0] got, input logic [63:0] exp);
        begin
            checks++;
            if (got !== exp)
            begin
                n_mismatch++;
                $display("Error at %0t ns: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task sx(input logic [7:0] ins, input logic [31:0] wd, input logic lsb, input logic w3,
        input int nb);
        i_host_serial_model.xfer(ins, wd, lsb, w3, nb, rd);
    endtask

    // Strobe held well past the synchroniser
    task upd();
        begin
            io_update = 1'b1;
            tick(4);
            io_update = 1'b0;
            tick(8);
        end
    endtask

    task par_wr(input logic [7:0] addr, input logic [15:0] data, input logic wide);
        begin
            function_select = FSEL_PARALLEL;
            par_in = {data, addr, 5'h0, 2'b11, wide};
            tick(4);
            par_in[PAR_WR_N_BIT] = 1'b0;
            tick(4);
            par_in[PAR_WR_N_BIT] = 1'b1;
            tick(4);
        end
    endtask

    task par_rd(input logic [7:0] addr, input logic wide, input logic [31:0] exp);
        begin
            par_in = {16'h0, addr, 5'h0, 2'b10, wide};
            tick(6);
            cmp(port_out, exp);
            par_in[PAR_RD_N_BIT] = 1'b1;
            tick(6);
        end
    endtask

    // Direct word, then 40 cycles: two full 16-cycle sample periods plus latency
    task dsend(input logic [3:0] code, input logic [31:0] v, input logic [59:0] exp);
        begin
            function_select = code;
            par_in = v;
            tick(40);
            cmp(core_word, exp);
        end
    endtask

    task end_of_test();
        begin
            $display("mismatches %0d checks %0d", n_mismatch, checks);
            if (n_mismatch == 0 && checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        $display("Error at %0t ns: run did not finish", $time);
        end_of_test();
    end

    initial
    begin
        n_mismatch = 0;
        checks = 0;
        function_select = FSEL_SERIAL;
        par_in = 32'h0;
        io_update = 1'b0;
        profile_select_pins = 3'h0;
        reset_n = 1'b0;
        tick(2);
        reset_n = 1'b1;
        cmp({port_oe, port_out}, 64'h0);
        tick(2);
        cmp({port_oe, port_out}, 64'h0);
        tick(2);
        sx(8'h00, 32'h0002_0100, 1'b0, 1'b0, 40);
        upd();
        sx(8'hc0, 32'h0, 1'b0, 1'b0, 40);
        cmp(rd, 32'h0002_0100);
        cmp(i_host_serial_model.sdo_used, 1'b0);
        sx(8'h00, 32'h0002_0103, 1'b0, 1'b0, 40);
        upd();
        sx(8'h80, 32'h0, 1'b1, 1'b1, 40);
        cmp(rd, 32'h0002_0103);
        cmp(i_host_serial_model.sdo_used, 1'b1);
        sx(8'h00, 32'h0002_0100, 1'b1, 1'b1, 40);
        upd();
        sx(8'h0d, 32'hdead_beef, 1'b0, 1'b0, 40);
        upd();
        profile_select_pins = 3'h1;
        tick(10);
        sx(8'h8b, 32'h0, 1'b0, 1'b0, 40);
        cmp(rd, 32'hdead_beef);
        // One whole byte and half of the next, then abort
        sx(8'h01, 32'ha55a_0000, 1'b0, 1'b0, 20);
        i_host_serial_model.resync();
        upd();
        sx(8'h81, 32'h0, 1'b0, 1'b0, 40);
        cmp(rd, 32'ha500_0000);
        dsend(4'h2, 32'h89ab_cdef, {32'h89ab_cdef, 16'h0, 12'h0});
        dsend(4'h3, 32'h89ab_cdef, {32'hcdef_89ab, 16'h0, 12'h0});
        dsend(4'h4, 32'h1234_f567, {32'hcdef_89ab, 16'h1234, 12'h567});
        dsend(4'h5, 32'hfabc_4321, {32'hcdef_89ab, 16'h4321, 12'habc});
        dsend(4'h6, 32'h0102_03f7, {32'h0102_03ab, 16'h4321, 12'h7bc});
        dsend(4'hd, 32'hc0ff_ee11, {32'h01c0_ffee, 16'h4311, 12'h7bc});
        dsend(4'he, 32'h5555_5555, {32'h01c0_ffee, 16'h4311, 12'h7bc});
        par_wr(8'h02, 16'h0000, 1'b0);
        par_wr(8'h05, 16'h8000, 1'b1);
        upd();
        par_rd(8'h01, 1'b0, 32'h0001_0000);
        par_rd(8'h05, 1'b1, 32'h8000_0000);
        dsend(4'h2, 32'h1111_2222, {32'h01c0_ffee, 16'h4311, 12'h7bc});
        dsend(4'h4, 32'h5678_0abc, {32'h01c0_ffee, 16'h4311, 12'h7bc});
        // Matched paths: four clocks into the strobe no field may have moved yet
        io_update = 1'b1;
        tick(4);
        cmp(core_word, {32'h01c0_ffee, 16'h4311, 12'h7bc});
        io_update = 1'b0;
        tick(8);
        cmp(core_word, {32'h1111_2222, 16'h5678, 12'habc});
        dsend(4'h9, 32'h3333_3344, {32'h1111_2222, 16'h5678, 12'habc});
        profile_select_pins = 3'h2;
        tick(10);
        cmp(core_word, {32'h3333_3322, 16'h5644, 12'habc});
        par_wr(8'h01, 16'h0000, 1'b0);
        upd();
        dsend(4'h4, 32'h1357_0123, {32'h3333_3322, 16'h5644, 12'habc});
        upd();
        cmp(core_word, {32'h3333_3322, 16'h1357, 12'habc});
        end_of_test();
    end
endmodule

// [verification/dds_host_port_props.sv]
// Pin-level checks on the synthesizer host port
`timescale 1ns/1ps
module dds_host_port_props
    import dds_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Host pins
    input wire logic [3:0] function_select,
    input wire logic [31:0] port_in,
    input wire logic io_update,
    input wire logic [2:0] profile_select_pins,
    input wire logic [31:0] port_out,
    input wire logic [31:0] port_oe,
    // Synthesis core
    input dds_port_pkg::core_word_t core_word
);
    logic [3:0] fall_age_ff;
    logic ser_mode;
    logic par_mode;

    assign ser_mode = function_select == FSEL_SERIAL;
    assign par_mode = function_select == FSEL_PARALLEL;

    // Cycles since the raw serial clock fell; saturates so it never wraps
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            fall_age_ff <= 4'hf;
        else if ($fell(port_in[SER_SCLK_BIT]))
            fall_age_ff <= 4'h0;
        else if (fall_age_ff != 4'hf)
            fall_age_ff <= fall_age_ff + 4'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    reset_clear_a: assert property (disable iff (1'b0)
        !reset_n |=> port_oe == 32'h0 && port_out == 32'h0 && core_word == '0)
        else $error("outputs not cleared in reset");
    out_gated_a: assert property ((port_out & ~port_oe) == 32'h0)
        else $error("port driven value outside its enables");
    serial_pins_a: assert property (ser_mode [*5] |-> (port_oe & 32'hffff_fff3) == 32'h0)
        else $error("serial mode drives a pin other than the data pins");
    cs_idle_a: assert property ((ser_mode && port_in[SER_CS_N_BIT]) [*5] |-> port_oe[3:2] == 2'h0)
        else $error("data pins driven while deselected");
    direct_quiet_a: assert property ((function_select >= FSEL_DIRECT_FIRST) [*5] |-> port_oe == 32'h0)
        else $error("port driven in direct or unused mode");
    par_narrow_a: assert property ((par_mode && port_in[2:0] == 3'b100) [*5]
        |-> port_oe == 32'h00ff_0000)
        else $error("narrow parallel read enables wrong");
    par_wide_a: assert property ((par_mode && port_in[2:0] == 3'b101) [*5]
        |-> port_oe == 32'hffff_0000)
        else $error("wide parallel read enables wrong");
    par_idle_a: assert property ((par_mode && port_in[PAR_RD_N_BIT]) [*5] |-> port_oe == 32'h0)
        else $error("parallel port driven without a read");
    freq_rate_a: assert property ($changed(core_word.freq) |=> $stable(core_word.freq) [*8])
        else $error("frequency updated faster than the port sample rate");
    read_edge_a: assert property (ser_mode && port_oe[2] && $past(port_oe[2])
        && $changed(port_out[2]) |-> fall_age_ff <= 4'h6)
        else $error("read bit moved away from a falling serial clock");

    cover property (ser_mode && port_oe[SER_SDIO_BIT]);
    cover property (port_oe == 32'hffff_0000);
    cover property ($changed(core_word.phase));
endmodule

bind dds_host_port_mode_select dds_host_port_props i_dds_host_port_props (.clk, .reset_n,
    .function_select, .port_in, .io_update, .profile_select_pins, .port_out, .port_oe,
    .core_word);

// [verification/host_serial_model.sv]
// Host serial controller model for the five serial pins of the port
`timescale 1ns/1ps
module host_serial_model
(
    // Clock
    input wire logic clk,
    // Device side of the port
    input wire logic [31:0] port_out,
    input wire logic [31:0] port_oe,
    output logic [4:0] ser_pins
);
    logic cs_n;
    logic sclk;
    logic sync;
    logic sdio_en;
    logic sdio_drv;
    logic sdio_wire;
    logic sdo_wire;
    logic sdio_last = 1'b0;
    logic sdo_last = 1'b0;
    logic sdo_used;

    // A line nobody drives shows the inverse of its last level, never a stale copy
    assign sdio_wire = sdio_en ? sdio_drv : (port_oe[2] ? port_out[2] : ~sdio_last);
    assign sdo_wire = port_oe[3] ? port_out[3] : ~sdo_last;
    assign ser_pins = {sync, sdo_wire, sdio_wire, sclk, cs_n};

    always @(posedge clk)
    begin
        sdio_last <= sdio_wire;
        sdo_last <= sdo_wire;
    end

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sync = 1'b0;
        sdio_en = 1'b1;
        sdio_drv = 1'b0;
        sdo_used = 1'b0;
    end

    // Serial clock stands low outside frames; 80 ns per bit
    task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, input logic lsb,
        input logic w3, input int nbits, output logic [31:0] rd);
        int j;
        begin
            rd = 32'h0;
            sdo_used = 1'b0;
            @(negedge clk);
            cs_n = 1'b0;
            for (int i = 0; i < nbits; i++)
            begin
                j = i - 8;
                sclk = 1'b0;
                sdio_en = !(ins[7] && i >= 8) || w3;
                sdio_drv = (i < 8) ? ins[lsb ? i : 7 - i] : wd[lsb ? j : 31 - j];
                repeat (4) @(negedge clk);
                sclk = 1'b1;
                repeat (3) @(negedge clk);
                if (i >= 8)
                    rd[lsb ? j : 31 - j] = w3 ? sdo_wire : sdio_wire;
                sdo_used = sdo_used | port_oe[3];
                @(negedge clk);
            end
            sclk = 1'b0;
            sdio_en = 1'b1;
            cs_n = 1'b1;
            repeat (4) @(negedge clk);
        end
    endtask

    // Realigns the device after a cycle cut short
    task automatic resync();
        begin
            cs_n = 1'b0;
            sync = 1'b1;
            repeat (4) @(negedge clk);
            sync = 1'b0;
            cs_n = 1'b1;
            repeat (4) @(negedge clk);
        end
    endtask
endmodule
